// ===== verilog/fault_status_register.v
/*
 Fault and reset-history status register with its SPI slave port.
 Assumes rst_n is the power-on reset, the watchdog and safing machine
 resets and all fault levels come from logic on mclk, and the SPI pins
 come from outside (mode 0, 32-bit frames, MSB first).
*/
// Functional notes
// - watchdog reset flag bit3, cleared on read
// - safing reset flag bit2, cleared on read
// - power-on flag bit0, cleared on read
// - checksum checked after power-on, error bit11
// - watchdog lockout shown live at bit7
// - watchdog reset latch shown at bit5
// - summary fault bit ORs whole register
// - 11-bit status word in top bits
`timescale 1ns/1ps
`include "fault_status_consts.vh"
module fault_status_register (
  input wire mclk,
  input wire rst_n,
  input wire sclk,
  input wire csN,
  input wire mosi,
  input wire watchdogMachineReset,
  input wire safingMachineReset,
  input wire wd1Lockout,
  input wire wd1TestMode,
  input wire wd1ResetLatch,
  input wire boostOvertemp,
  input wire oscCrossErr,
  input wire [15:0] otmCrcCalc,
  input wire [15:0] otmCrcRef,
  input wire [10:0] statusOther,
  output reg miso_r,
  output reg misoOe_r
);
  wire [2:0] pinS2;
  wire [2:0] pinS3;
  reg sclkSt_r;
  reg csSt_r;
  reg porFlag_r;
  reg safeFlag_r;
  reg wdogFlag_r;
  reg crcErr_r;
  reg crcDone_r;
  reg lock_r;
  reg latch_r;
  reg testMode_r;
  reg boostOt_r;
  reg oscErr_r;
  reg spiFault_r;
  reg ridErr_r;
  reg respIsFault_r;
  reg [31:0] txShift_r;
  reg [31:0] rxShift_r;
  reg [5:0] bitCnt_r;
  reg [`FS_WIDTH-1:0] snap_r;
  reg snapSpiFault_r;
  reg [`FS_WIDTH-1:0] faultWord;
  reg [`SW_WIDTH-1:0] statusWord;
  wire summary;
  wire sclkStable;
  wire csStable;
  wire sclkRise;
  wire sclkFall;
  wire frameStart;
  wire frameEnd;
  wire frameOk;
  wire [7:0] rxAddr;

  function isFaultAddr;
    input [7:0] addr;
    begin
      isFaultAddr = (addr == `FS_OFFSET);
    end
  endfunction

  // idle levels: sclk low, chip select high
  pin_sync #(
    .W(`SYNC_STAGES),
    .INIT(3'b010)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({mosi, csN, sclk}),
    .stage2(pinS2),
    .stage3(pinS3)
  );

  assign sclkStable = (pinS2[0] == pinS3[0]);
  assign csStable = (pinS2[1] == pinS3[1]);
  assign sclkRise = sclkStable && pinS3[0] && !sclkSt_r && !csSt_r;
  assign sclkFall = sclkStable && !pinS3[0] && sclkSt_r && !csSt_r;
  assign frameStart = csStable && !pinS3[1] && csSt_r;
  assign frameEnd = csStable && pinS3[1] && !csSt_r;
  assign frameOk = frameEnd && (bitCnt_r == `FRAME_BITS);
  assign rxAddr = rxShift_r[`ADDR_HI:`ADDR_LO];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSt_r <= 1'b0;
      csSt_r <= 1'b1;
    end else begin
      if (sclkStable) begin
        sclkSt_r <= pinS3[0];
      end
      if (csStable) begin
        csSt_r <= pinS3[1];
      end
    end
  end

  always @* begin
    faultWord = `FS_ZERO;
    faultWord[`FS_POR] = porFlag_r;
    faultWord[`FS_SAFE_RST] = safeFlag_r;
    faultWord[`FS_WDOG_RST] = wdogFlag_r;
    faultWord[`FS_WD1_LATCH] = latch_r;
    faultWord[`FS_WD1_TEST] = testMode_r;
    faultWord[`FS_WD1_LOCK] = lock_r;
    faultWord[`FS_OTM_CRC] = crcErr_r;
    faultWord[`FS_OSC_ERR] = oscErr_r;
    faultWord[`FS_BOOST_OT] = boostOt_r;
  end

  assign summary = |faultWord;

  always @* begin
    statusWord = statusOther;
    statusWord[`SW_SPI_FAULT] = spiFault_r;
    statusWord[`SW_SUMMARY] = summary;
    statusWord[`SW_BAD_READ] = ridErr_r;
  end

  // reset history: a reset still asserted wins over the read clear
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      porFlag_r <= `FS_POR_RESET;
      safeFlag_r <= `FS_SAFE_RESET;
      wdogFlag_r <= `FS_WDOG_RESET;
    end else begin
      porFlag_r <= porFlag_r & ~(frameOk & snap_r[`FS_POR]);
      wdogFlag_r <= watchdogMachineReset |
        (wdogFlag_r & ~(frameOk & snap_r[`FS_WDOG_RST]));
      safeFlag_r <= safingMachineReset | watchdogMachineReset |
        (safeFlag_r & ~(frameOk & snap_r[`FS_SAFE_RST]));
    end
  end

  // checksum judged once, on the first edge after power-on release
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crcDone_r <= 1'b0;
      crcErr_r <= 1'b0;
    end else if (!crcDone_r) begin
      crcDone_r <= 1'b1;
      crcErr_r <= (otmCrcCalc != otmCrcRef);
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= `FS_LIVE_RESET;
      latch_r <= `FS_LIVE_RESET;
      testMode_r <= `FS_LIVE_RESET;
      boostOt_r <= `FS_LIVE_RESET;
      oscErr_r <= `FS_LIVE_RESET;
    end else begin
      boostOt_r <= boostOvertemp;
      oscErr_r <= oscCrossErr;
      if (watchdogMachineReset) begin
        lock_r <= `FS_LIVE_RESET;
        latch_r <= `FS_LIVE_RESET;
        testMode_r <= `FS_LIVE_RESET;
      end else begin
        lock_r <= wd1Lockout;
        latch_r <= wd1ResetLatch;
        testMode_r <= safingMachineReset ? `FS_LIVE_RESET : wd1TestMode;
      end
    end
  end

  // response to a frame's read address goes out in the following frame
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_r <= 32'h0000_0000;
      rxShift_r <= 32'h0000_0000;
      bitCnt_r <= 6'h00;
      snap_r <= `FS_ZERO;
      snapSpiFault_r <= 1'b0;
      miso_r <= 1'b0;
      misoOe_r <= 1'b0;
    end else begin
      misoOe_r <= !csSt_r;
      if (frameStart) begin
        txShift_r <= {statusWord, 1'b0,
          (respIsFault_r ? faultWord : `FS_ZERO)};
        snap_r <= respIsFault_r ? faultWord : `FS_ZERO;
        snapSpiFault_r <= spiFault_r;
        miso_r <= statusWord[`SW_SPI_FAULT];
        bitCnt_r <= 6'h00;
      end else if (sclkRise) begin
        rxShift_r <= {rxShift_r[30:0], pinS3[2]};
        if (bitCnt_r != 6'h3f) begin
          bitCnt_r <= bitCnt_r + 6'h01;
        end
      end else if (sclkFall) begin
        txShift_r <= {txShift_r[30:0], 1'b0};
        miso_r <= txShift_r[30];
      end
    end
  end

  // only the address field is decoded; data bits are shifted into rxShift_r but never used
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      respIsFault_r <= 1'b0;
      ridErr_r <= 1'b0;
      spiFault_r <= 1'b0;
    end else if (frameEnd) begin
      if (frameOk) begin
        respIsFault_r <= isFaultAddr(rxAddr);
        ridErr_r <= !isFaultAddr(rxAddr);
        spiFault_r <= spiFault_r & ~snapSpiFault_r;
      end else begin
        respIsFault_r <= 1'b0;
        ridErr_r <= 1'b0;
        spiFault_r <= 1'b1;
      end
    end
  end
endmodule

// ===== verilog/fault_status_consts.vh
/*
 Holds the constants of the fault and reset-history status register:
 its offset, field positions, reset values and the SPI frame layout.
 Assumes it is included by bare name from the design files.
*/
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

`define FS_OFFSET 8'h00
`define FS_WIDTH 20
`define FS_ZERO 20'h0_0000

`define FS_POR 0
`define FS_SAFE_RST 2
`define FS_WDOG_RST 3
`define FS_WD1_LATCH 5
`define FS_WD1_TEST 6
`define FS_WD1_LOCK 7
`define FS_OTM_CRC 11
`define FS_OSC_ERR 16
`define FS_BOOST_OT 17

`define FS_POR_RESET 1'b1
`define FS_SAFE_RESET 1'b1
`define FS_WDOG_RESET 1'b1
`define FS_LIVE_RESET 1'b0

`define FRAME_BITS 6'h20
`define ADDR_HI 31
`define ADDR_LO 24
`define SW_WIDTH 11
`define SW_SPI_FAULT 10
`define SW_SUMMARY 4
`define SW_BAD_READ 0
`define SYNC_STAGES 3

`endif

// ===== verilog/pin_sync.v
/*
 Three-stage synchroniser for a group of pin inputs.
 Assumes the caller judges a change only by the second and third stage.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 3,
  parameter [W-1:0] INIT = 3'b000
) (
  input wire mclk,
  input wire rst_n,
  input wire [W-1:0] pinIn,
  output wire [W-1:0] stage2,
  output wire [W-1:0] stage3
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      // first stage feeds only the second
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= INIT[i];
          s2_r <= INIT[i];
          s3_r <= INIT[i];
        end else begin
          s1_r <= pinIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      assign stage2[i] = s2_r;
      assign stage3[i] = s3_r;
    end
  endgenerate
endmodule

// ===== bench/fault_status_sva.sv
/* SPI pin checks of the fault status register.
   Assumes a bind to the top module and a host with >=6 cycle phases. */
`timescale 1ns/1ps
module fault_status_sva (
  input wire mclk,
  input wire rst_n,
  input wire sclk,
  input wire csN,
  input wire miso_r,
  input wire misoOe_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_idle; csN [*8] |-> !misoOe_r; endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_on; $fell(csN) |-> ##[2:8] misoOe_r; endproperty
  a_on: assert property (p_on) else $error("no drive");
  property p_off; $rose(csN) |-> ##[2:8] !misoOe_r; endproperty
  a_off: assert property (p_off) else $error("drive kept");
  property p_held; (!csN) [*8] |-> misoOe_r; endproperty
  a_held: assert property (p_held) else $error("drive lost");
  property p_early; $rose(misoOe_r) |-> !$past(csN, 2); endproperty
  a_early: assert property (p_early) else $error("early drive");
  property p_hi; sclk [*8] |-> $stable(miso_r); endproperty
  a_hi: assert property (p_hi) else $error("bit moved high");
  property p_lo; (!sclk && !csN) [*8] |-> $stable(miso_r); endproperty
  a_lo: assert property (p_lo) else $error("bit moved low");
  property p_rel; $rose(rst_n) |-> !misoOe_r && !miso_r; endproperty
  a_rel: assert property (p_rel) else $error("out after reset");
endmodule
bind fault_status_register fault_status_sva chk (.mclk(mclk),
  .rst_n(rst_n), .sclk(sclk), .csN(csN), .miso_r(miso_r),
  .misoOe_r(misoOe_r));

// ===== bench/spi_host.sv
/* Host SPI master model, mode 0, MSB first.
   Assumes its task is entered just after a falling mclk edge. */
`timescale 1ns/1ps
module spi_host (
  input wire mclk,
  input wire miso_r,
  output reg sclk,
  output reg csN,
  output reg mosi
);
  integer i;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // n below 32 sends a short frame on purpose
  task xfer(input [31:0] tx, input integer n, input integer h,
    output [31:0] rx);
    begin
      rx = 32'h0000_0000;
      csN = 1'b0;
      repeat (8) @(negedge mclk);
      for (i = 31; i > 31 - n; i = i - 1) begin
        mosi = tx[i];
        repeat (h) @(negedge mclk);
        rx[i] = miso_r;
        sclk = 1'b1;
        repeat (h) @(negedge mclk);
        sclk = 1'b0;
      end
      repeat (h) @(negedge mclk);
      csN = 1'b1;
      // released line must not keep the stale bit
      mosi = ~mosi;
      repeat (h) @(negedge mclk);
    end
  endtask
endmodule

// ===== bench/test_fault_status_register.sv
/* Self-checking bench for the fault status register.
   Assumes the host model and the bound checker beside it. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module test_fault_status_register;
  reg mclk = 0, rst_n = 0, wdogRst = 0, safeRst = 0, sp = 0, rid = 0;
  reg [4:0] lv = 0;
  reg [15:0] crcA = 0, crcB = 0;
  reg [10:0] g = 0;
  reg [31:0] rx;
  reg [31:0] e;
  wire sclk, csN, mosi, miso_r, misoOe_r;
  integer seed = 32'h0000_9b97, miscompares = 0, n_checks = 0;
  integer st, pa, n, k;
  always #4 mclk = ~mclk;
  spi_host host (.mclk(mclk), .miso_r(miso_r), .sclk(sclk), .csN(csN),
    .mosi(mosi));
  fault_status_register DUT (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
    .csN(csN), .mosi(mosi), .watchdogMachineReset(wdogRst),
    .safingMachineReset(safeRst),
    .wd1Lockout(lv[0]), .wd1TestMode(lv[1]), .wd1ResetLatch(lv[2]),
    .boostOvertemp(lv[3]), .oscCrossErr(lv[4]), .otmCrcCalc(crcA),
    .otmCrcRef(crcB), .statusOther(g), .miso_r(miso_r), .misoOe_r(misoOe_r));
  task report_and_stop;
    begin
      if (miscompares == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task rst(input m);
    begin
      rst_n = 0;
      crcA = $random(seed);
      crcB = m ? ~crcA : crcA;
      repeat (8) @(negedge mclk);
      rst_n = 1;
      st = m ? 32'h0000_080D : 32'h0000_000D;
      pa = 1;
      sp = 0;
      rid = 0;
      repeat (4) @(negedge mclk);
    end
  endtask
  task frame;
    reg [19:0] d;
    reg [7:0] a;
    begin
      k = $random(seed) & 7;
      wdogRst = (k == 0);
      safeRst = (k == 1);
      repeat (3) @(negedge mclk);
      wdogRst = 0;
      safeRst = 0;
      st = st | (k == 0 ? 12 : k == 1 ? 4 : 0);
      lv = $random(seed);
      g = $random(seed);
      repeat (4) @(negedge mclk);
      d = {lv[3], lv[4], 8'h00, lv[0], lv[1], lv[2], 5'h00} | st[19:0];
      e = {sp, g[9:5], |d, g[3:1], rid, 1'b0, pa == 0 ? d : 20'h0_0000};
      n = k == 2 ? 20 : 32;
      a = ($random(seed) & 3) == 0 ? $random(seed) : 8'h00;
      host.xfer({a, 24'($random(seed))}, n, 6 + ($random(seed) & 3), rx);
      if (n == 32) begin
        `CHK(rx, e)
        if (pa == 0) st = st & ~13;
        sp = 0;
        pa = a;
        rid = (a != 8'h00);
      end else begin
        // a refused frame also drops the pending read address
        sp = 1;
        pa = 1;
        rid = 0;
      end
    end
  endtask
  initial begin
    rst(1);
    repeat (30) frame;
    rst(0);
    repeat (15) frame;
    report_and_stop;
  end
  initial begin
    #500000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule
